// File: fsf_pkg.sv
// Purpose: constants for the flash supervisory service sequencer
// Assumes: 8-bit data, page-0 parameter block, 128-byte blocks
// Notes: register offsets are byte addresses on the plain register port

package fsf_pkg;

   // ************************************************
   // parameter block in ram page 0
   // ************************************************
   localparam logic [7:0] ADDR_KEY_ONE = 8'hf8;
   localparam logic [7:0] ADDR_KEY_TWO = 8'hf9;
   localparam logic [7:0] ADDR_BLOCK_NUM = 8'hfa;
   localparam logic [7:0] ADDR_POINTER = 8'hfb;
   localparam logic [7:0] KEY_ONE_VALUE = 8'h3a;
   localparam logic [7:0] SP_KEY_OFFSET = 8'h03;

   // ************************************************
   // function codes
   // ************************************************
   localparam logic [7:0] FN_BULK_ERASE = 8'h05;
   localparam logic [7:0] FN_CHECKSUM = 8'h07;
   localparam logic [7:0] FN_PLAIN_TRIM = 8'h08;
   localparam logic [7:0] FN_CHECKED_TRIM = 8'h09;
   localparam logic [7:0] FN_PROG_VERIFY = 8'h0a;
   localparam logic [7:0] FN_BOOT_RESET = 8'h0f;

   // ************************************************
   // results
   // ************************************************
   localparam logic [7:0] RES_OK = 8'h00;
   localparam logic [7:0] RES_PROT_FAIL = 8'h01;
   localparam logic [7:0] RES_VERIFY_FAIL = 8'h04;

   // ************************************************
   // register port map
   // ************************************************
   localparam logic [7:0] REG_MOVE_READ_PAGE = 8'hd4;
   localparam logic [7:0] REG_MOVE_WRITE_PAGE = 8'hd5;
   localparam logic [7:0] REG_SYS_STATUS_ONE = 8'hd6;
   localparam logic [7:0] REG_SVC_STATUS = 8'hd7;
   localparam int IRF_BIT = 0;
   localparam logic [7:0] PAGE_RESET = 8'h00;

   // ************************************************
   // sizes and timing
   // ************************************************
   localparam int BLOCK_BYTES = 128;
   localparam int TRIM_BUF_BYTES = 38;
   localparam int TRIM_BYTES = 8;
   localparam int HIDDEN_BLOCKS = 3;
   localparam int CLK_MHZ = 100;
   localparam int VERIFY_EXTRA_US = 1000;
   localparam int VERIFY_EXTRA_CYC = VERIFY_EXTRA_US * CLK_MHZ;

endpackage

// File: fsf_sequencer.sv
// Purpose: flash supervisory service sequencer, run on a supervisor call
// Assumes: single-cycle ram and flash ports, flash program ends by done pulse
// Notes: protection is 2 bits per block; mode 11 blocks internal writes
`timescale 1ns/1ps

module fsf_sequencer #(
   parameter int NUM_BLOCKS = 64,
   parameter int VERIFY_EXTRA_CYC = fsf_pkg::VERIFY_EXTRA_CYC
) (
   input wire logic clk, // core clock
   input wire logic arst_n, // async reset, low active
   input wire logic call_req, // supervisor call pulse
   input wire logic [7:0] call_func, // accumulator function code
   input wire logic [7:0] call_sp, // stack pointer at call
   input wire logic call_external, // call issued by external programmer
   output logic call_busy, // service running
   output logic call_done, // service finished pulse
   output logic core_halt, // core halted
   output logic [7:0] acc_out, // accumulator returned
   output logic ram_we, // ram write strobe
   output logic [10:0] ram_addr, // ram address, page and offset
   output logic [7:0] ram_wdata, // ram write data
   input wire logic [7:0] ram_rdata, // ram read data, same cycle
   output logic [13:0] flash_addr, // flash byte address
   input wire logic [7:0] flash_rdata, // flash read data, same cycle
   output logic latch_we, // page latch write
   output logic [6:0] latch_addr, // page latch index
   output logic [7:0] latch_wdata, // page latch data
   output logic flash_prog, // program block pulse
   output logic flash_erase_all, // erase user data and protection pulse
   input wire logic flash_op_done, // program or erase done pulse
   input wire logic [1:0] prot_mode, // protection of addressed block
   input wire logic [7:0] trim_rdata, // stored trim byte
   output logic [2:0] trim_addr, // trim byte index
   output logic trim_we, // load trim register
   output logic [7:0] trim_wdata, // trim register data
   input wire logic trim_sum_ok, // stored trim checksum compares good
   output logic internal_reset, // internal hardware reset pulse
   output logic soft_boot, // start soft boot, then run at 0000h
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // register write data
   input wire logic reg_we, // register write strobe
   input wire logic reg_re, // register read strobe
   output logic [7:0] reg_rdata // read data, cycle after strobe
);

   typedef enum logic [3:0] {
      S_IDLE, S_KEY_BYTE_ONE, S_KEY_BYTE_TWO, S_PARAM, S_PTR, S_ERASE, S_SUM, S_TRIM, S_CLEAR,
      S_LATCH, S_PROG, S_VERIFY, S_WAIT, S_RESULT, S_HALT
   } fsf_state_e;

   localparam int BW = $clog2(NUM_BLOCKS * fsf_pkg::BLOCK_BYTES);

   // ************************************************
   // state
   // ************************************************
   fsf_state_e st_r, st_nxt;
   logic [7:0] func_r, func_nxt, sp_r, sp_nxt, blk_r, blk_nxt, ptr_r, ptr_nxt;
   logic [BW-1:0] idx_r, idx_nxt, lim_r, lim_nxt;
   logic [15:0] sum_r, sum_nxt;
   logic [31:0] wait_r, wait_nxt;
   logic [7:0] acc_r, acc_nxt, k1_r, k1_nxt, k2_r, k2_nxt;
   logic bad_r, bad_nxt, irf_r, irf_nxt, halt_r, halt_nxt;
   logic [7:0] mvr_r, mvr_nxt, mvw_r, mvw_nxt, rd_r, rd_nxt;
   logic [1:0] res_ph_r, res_ph_nxt;

   function automatic logic [10:0] page0(input logic [7:0] a);
      return {3'b000, a};
   endfunction

   function automatic logic [10:0] paged(input logic [7:0] pg, input logic [7:0] a);
      return {pg[2:0], a};
   endfunction

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      st_nxt = st_r;
      func_nxt = func_r;
      sp_nxt = sp_r;
      blk_nxt = blk_r;
      ptr_nxt = ptr_r;
      idx_nxt = idx_r;
      lim_nxt = lim_r;
      sum_nxt = sum_r;
      wait_nxt = wait_r;
      acc_nxt = acc_r;
      k1_nxt = k1_r;
      k2_nxt = k2_r;
      bad_nxt = bad_r;
      irf_nxt = irf_r;
      halt_nxt = halt_r;
      res_ph_nxt = res_ph_r;
      ram_we = 1'b0;
      ram_addr = 11'h000;
      ram_wdata = 8'h00;
      flash_addr = '0;
      latch_we = 1'b0;
      latch_addr = 7'h00;
      latch_wdata = 8'h00;
      flash_prog = 1'b0;
      flash_erase_all = 1'b0;
      trim_addr = 3'h0;
      trim_we = 1'b0;
      trim_wdata = 8'h00;
      internal_reset = 1'b0;
      soft_boot = 1'b0;
      call_done = 1'b0;
      case (st_r)
         S_IDLE: begin
            if (call_req && !halt_r) begin
               func_nxt = call_func;
               sp_nxt = call_sp;
               st_nxt = S_KEY_BYTE_ONE;
            end
         end
         S_KEY_BYTE_ONE: begin
            ram_addr = page0(fsf_pkg::ADDR_KEY_ONE);
            st_nxt = (ram_rdata == fsf_pkg::KEY_ONE_VALUE) ? S_KEY_BYTE_TWO : S_HALT;
         end
         // second key must be sp plus 3
         S_KEY_BYTE_TWO: begin
            ram_addr = page0(fsf_pkg::ADDR_KEY_TWO);
            if (ram_rdata != 8'(sp_r + fsf_pkg::SP_KEY_OFFSET)) begin
               st_nxt = S_HALT;
            end else begin
               st_nxt = S_PARAM;
            end
         end
         S_PARAM: begin
            ram_addr = page0(fsf_pkg::ADDR_BLOCK_NUM);
            blk_nxt = ram_rdata;
            st_nxt = S_PTR;
         end
         // dispatch on function code; unknown halts
         S_PTR: begin
            ram_addr = page0(fsf_pkg::ADDR_POINTER);
            ptr_nxt = ram_rdata;
            // protection is looked up for the named block
            flash_addr = 14'({blk_r, 7'h00});
            idx_nxt = '0;
            sum_nxt = 16'h0000;
            acc_nxt = 8'h00;
            k1_nxt = fsf_pkg::RES_OK;
            k2_nxt = 8'h00;
            bad_nxt = 1'b0;
            case (func_r)
               // bulk erase; internal callers halt untouched
               fsf_pkg::FN_BULK_ERASE: st_nxt = call_external ? S_ERASE : S_HALT;
               fsf_pkg::FN_CHECKSUM: begin
                  // zero or oversize count means whole bank
                  if (blk_r == 8'h00 || 32'(blk_r) >= 32'(NUM_BLOCKS)) begin
                     lim_nxt = BW'(NUM_BLOCKS * fsf_pkg::BLOCK_BYTES - 1);
                  end else begin
                     lim_nxt = BW'(32'(blk_r) * fsf_pkg::BLOCK_BYTES - 1);
                  end
                  st_nxt = S_SUM;
               end
               fsf_pkg::FN_PLAIN_TRIM: st_nxt = S_TRIM;
               fsf_pkg::FN_CHECKED_TRIM: st_nxt = (mvr_r == mvw_r) ? S_TRIM : S_HALT;
               fsf_pkg::FN_PROG_VERIFY: begin
                  if (32'(blk_r) >= 32'(NUM_BLOCKS)) begin
                     st_nxt = S_HALT;
                  end else if (prot_mode == 2'b11) begin
                     k1_nxt = fsf_pkg::RES_PROT_FAIL;
                     st_nxt = S_RESULT;
                  end else begin
                     st_nxt = S_LATCH;
                  end
               end
               fsf_pkg::FN_BOOT_RESET: begin
                  internal_reset = 1'b1;
                  soft_boot = 1'b1;
                  st_nxt = S_IDLE;
               end
               default: st_nxt = S_HALT;
            endcase
         end
         // erase pulse covers user blocks and protection only
         S_ERASE: begin
            flash_erase_all = (wait_r == 32'd0);
            wait_nxt = 32'd1;
            if (flash_op_done) begin
               wait_nxt = 32'd0;
               st_nxt = S_RESULT;
            end
         end
         // sum bytes from block zero upward
         S_SUM: begin
            flash_addr = 14'(idx_r);
            sum_nxt = sum_r + {8'h00, flash_rdata};
            idx_nxt = idx_r + 1'b1;
            if (idx_r == lim_r) begin
               st_nxt = S_RESULT;
            end
         end
         // load every trim byte; checked form also tests trim_sum_ok
         S_TRIM: begin
            trim_addr = 3'(idx_r);
            trim_we = 1'b1;
            trim_wdata = trim_rdata;
            idx_nxt = idx_r + 1'b1;
            if (idx_r == BW'(fsf_pkg::TRIM_BYTES - 1)) begin
               idx_nxt = '0;
               if (func_r != fsf_pkg::FN_CHECKED_TRIM) begin
                  st_nxt = S_RESULT;
               end else begin
                  bad_nxt = !trim_sum_ok;
                  st_nxt = S_CLEAR;
               end
            end
         end
         // clear 38 work bytes, then reset if bad
         S_CLEAR: begin
            ram_we = 1'b1;
            ram_addr = paged(mvw_r, 8'(ptr_r + 8'(idx_r)));
            idx_nxt = idx_r + 1'b1;
            if (idx_r == BW'(fsf_pkg::TRIM_BUF_BYTES - 1)) begin
               if (bad_r) begin
                  internal_reset = 1'b1;
                  irf_nxt = 1'b1;
                  st_nxt = S_IDLE;
               end else begin
                  st_nxt = S_RESULT;
               end
            end
         end
         // step one: 128 bytes into page latch
         S_LATCH: begin
            ram_addr = paged(mvr_r, 8'(ptr_r + 8'(idx_r)));
            latch_we = 1'b1;
            latch_addr = 7'(idx_r);
            latch_wdata = ram_rdata;
            idx_nxt = idx_r + 1'b1;
            if (idx_r == BW'(fsf_pkg::BLOCK_BYTES - 1)) begin
               idx_nxt = '0;
               st_nxt = S_PROG;
            end
         end
         S_PROG: begin
            flash_prog = (wait_r == 32'd0);
            flash_addr = 14'({blk_r, 7'h00});
            wait_nxt = 32'd1;
            if (flash_op_done) begin
               wait_nxt = 32'd0;
               st_nxt = S_VERIFY;
            end
         end
         S_VERIFY: begin
            ram_addr = paged(mvr_r, 8'(ptr_r + 8'(idx_r)));
            flash_addr = 14'({blk_r, 7'(idx_r)});
            if (flash_rdata != ram_rdata) begin
               bad_nxt = 1'b1;
            end
            idx_nxt = idx_r + 1'b1;
            if (idx_r == BW'(fsf_pkg::BLOCK_BYTES - 1)) begin
               wait_nxt = 32'd0;
               st_nxt = S_WAIT;
            end
         end
         S_WAIT: begin
            wait_nxt = wait_r + 32'd1;
            if (wait_r >= 32'(VERIFY_EXTRA_CYC - 1)) begin
               wait_nxt = 32'd0;
               if (bad_r) begin
                  k1_nxt = fsf_pkg::RES_VERIFY_FAIL;
               end
               st_nxt = S_RESULT;
            end
         end
         // write key results back to page 0
         S_RESULT: begin
            ram_we = 1'b1;
            res_ph_nxt = res_ph_r + 2'd1;
            if (res_ph_r == 2'd0) begin
               ram_addr = page0(fsf_pkg::ADDR_KEY_ONE);
               ram_wdata = (func_r == fsf_pkg::FN_CHECKSUM) ? sum_r[7:0] : k1_r;
            end else begin
               ram_addr = page0(fsf_pkg::ADDR_KEY_TWO);
               ram_wdata = (func_r == fsf_pkg::FN_CHECKSUM) ? sum_r[15:8] : k2_r;
               res_ph_nxt = 2'd0;
               call_done = 1'b1;
               st_nxt = S_IDLE;
            end
         end
         S_HALT: begin
            halt_nxt = 1'b1;
         end
         default: st_nxt = S_IDLE;
      endcase
   end

   // ************************************************
   // register port
   // ************************************************
   always_comb begin
      mvr_nxt = mvr_r;
      mvw_nxt = mvw_r;
      rd_nxt = 8'h00;
      if (reg_we && reg_addr == fsf_pkg::REG_MOVE_READ_PAGE) begin
         mvr_nxt = reg_wdata;
      end
      if (reg_we && reg_addr == fsf_pkg::REG_MOVE_WRITE_PAGE) begin
         mvw_nxt = reg_wdata;
      end
      if (reg_re) begin
         case (reg_addr)
            fsf_pkg::REG_MOVE_READ_PAGE: rd_nxt = mvr_r;
            fsf_pkg::REG_MOVE_WRITE_PAGE: rd_nxt = mvw_r;
            fsf_pkg::REG_SYS_STATUS_ONE: rd_nxt = 8'(irf_r) << fsf_pkg::IRF_BIT;
            fsf_pkg::REG_SVC_STATUS: rd_nxt = {6'h00, halt_r, st_r != S_IDLE};
            default: rd_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= S_IDLE;
         func_r <= 8'h00;
         sp_r <= 8'h00;
         blk_r <= 8'h00;
         ptr_r <= 8'h00;
         idx_r <= '0;
         lim_r <= '0;
         sum_r <= 16'h0000;
         wait_r <= 32'd0;
         acc_r <= 8'h00;
         k1_r <= 8'h00;
         k2_r <= 8'h00;
         bad_r <= 1'b0;
         irf_r <= 1'b0;
         halt_r <= 1'b0;
         res_ph_r <= 2'd0;
         mvr_r <= fsf_pkg::PAGE_RESET;
         mvw_r <= fsf_pkg::PAGE_RESET;
         rd_r <= 8'h00;
      end else begin
         st_r <= st_nxt;
         func_r <= func_nxt;
         sp_r <= sp_nxt;
         blk_r <= blk_nxt;
         ptr_r <= ptr_nxt;
         idx_r <= idx_nxt;
         lim_r <= lim_nxt;
         sum_r <= sum_nxt;
         wait_r <= wait_nxt;
         acc_r <= acc_nxt;
         k1_r <= k1_nxt;
         k2_r <= k2_nxt;
         bad_r <= bad_nxt;
         irf_r <= irf_nxt;
         halt_r <= halt_nxt;
         res_ph_r <= res_ph_nxt;
         mvr_r <= mvr_nxt;
         mvw_r <= mvw_nxt;
         rd_r <= rd_nxt;
      end
   end

   assign call_busy = (st_r != S_IDLE) && (st_r != S_HALT);
   assign core_halt = halt_r;
   assign acc_out = acc_r;
   assign reg_rdata = rd_r;

endmodule

// File: fsf_partner.sv
// Purpose: ram, flash, page latch and trim store beside the sequencer
// Assumes: same-cycle reads; op done comes after a short or long delay
// Notes: corrupt spoils one programmed byte so that a verify can fail
`timescale 1ns/1ps
module fsf_partner (
   input wire logic clk, // core clock
   input wire logic ram_we, // ram write
   input wire logic [10:0] ram_addr, // ram address
   input wire logic [7:0] ram_wdata, // ram data in
   output logic [7:0] ram_rdata, // ram data out
   input wire logic [13:0] flash_addr, // flash address
   output logic [7:0] flash_rdata, // flash data
   input wire logic latch_we, // latch write
   input wire logic [6:0] latch_addr, // latch index
   input wire logic [7:0] latch_wdata, // latch data
   input wire logic flash_prog, // program pulse
   input wire logic flash_erase_all, // erase pulse
   output logic flash_op_done, // op done pulse
   input wire logic [2:0] trim_addr, // trim index
   output logic [7:0] trim_rdata, // stored trim
   input wire logic trim_we, // trim load
   input wire logic [7:0] trim_wdata, // trim value
   input wire logic corrupt, // spoil program
   input wire logic slow // long op delay
);
   logic [7:0] ram [2048];
   logic [7:0] flash [16384];
   logic [7:0] latch [128];
   logic [7:0] trim_src [8];
   logic [7:0] trim_reg [8];
   int prog_cnt = 0;
   int wait_cnt = 0;
   logic [6:0] blk;
   logic erasing;
   assign ram_rdata = ram[ram_addr];
   assign flash_rdata = flash[flash_addr];
   assign trim_rdata = trim_src[trim_addr];
   initial flash_op_done = 1'b0;
   // ****
   // memory model; the op result lands with the done pulse
   // ****
   always @(posedge clk) begin
      flash_op_done <= 1'b0;
      if (ram_we) ram[ram_addr] <= ram_wdata;
      if (latch_we) latch[latch_addr] <= latch_wdata;
      if (trim_we) trim_reg[trim_addr] <= trim_wdata;
      if (flash_prog) prog_cnt <= prog_cnt + 1;
      if (flash_prog || flash_erase_all) begin
         blk <= flash_addr[13:7];
         erasing <= flash_erase_all;
         wait_cnt <= slow ? 30 : 3;
      end else if (wait_cnt > 0) begin
         wait_cnt <= wait_cnt - 1;
         if (wait_cnt == 1) begin
            flash_op_done <= 1'b1;
            for (int i = 0; i < 16384; i++) if (erasing) flash[i] <= 8'h00;
            for (int i = 0; i < 128; i++)
               if (!erasing) flash[{blk, 7'(i)}] <= latch[i] ^ {7'h00, corrupt && i == 5};
         end
      end
   end
endmodule

// File: fsf_sva.sv
// Purpose: port-level checks of the supervisory service sequencer
// Assumes: one clock domain, async active-low reset
// Notes: latch writes are counted from each call request
`timescale 1ns/1ps
module fsf_sva (
   input wire logic clk, // clock
   input wire logic arst_n, // reset
   input wire logic call_req, // call
   input wire logic call_external, // external caller
   input wire logic call_busy, // busy
   input wire logic call_done, // done
   input wire logic core_halt, // halt
   input wire logic ram_we, // ram write
   input wire logic [10:0] ram_addr, // ram address
   input wire logic latch_we, // latch write
   input wire logic flash_prog, // program
   input wire logic flash_erase_all, // erase
   input wire logic trim_sum_ok, // trim sum good
   input wire logic internal_reset, // internal reset
   input wire logic soft_boot, // soft boot
   input wire logic [7:0] reg_addr, // reg address
   input wire logic [7:0] reg_wdata, // reg data in
   input wire logic reg_we, // reg write
   input wire logic reg_re, // reg read
   input wire logic [7:0] reg_rdata // reg data out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [7:0] latch_cnt_r, latch_cnt_nxt;
   always_comb begin
      latch_cnt_nxt = latch_cnt_r;
      if (call_req) latch_cnt_nxt = 8'h00;
      else if (latch_we) latch_cnt_nxt = latch_cnt_r + 8'h01;
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) latch_cnt_r <= 8'h00;
      else latch_cnt_r <= latch_cnt_nxt;
   end
   // ****
   // properties
   // ****
   sequence page_wr_rd;
      reg_we && reg_addr == fsf_pkg::REG_MOVE_READ_PAGE
      ##1 reg_re && reg_addr == fsf_pkg::REG_MOVE_READ_PAGE;
   endsequence
   chk_halt_sticky: assert property (core_halt |=> core_halt)
      else $error("halt dropped without reset");
   chk_erase_external: assert property (flash_erase_all |-> call_external)
      else $error("bulk erase for internal caller");
   chk_halt_no_write: assert property (core_halt |-> !(flash_prog || flash_erase_all || latch_we))
      else $error("flash touched while halted");
   chk_result_order: assert property (call_done |-> ram_we && ram_addr == 11'h0f9 && $past(ram_we) && $past(ram_addr) == 11'h0f8)
      else $error("result writes out of order");
   chk_latch_full: assert property (flash_prog |-> latch_cnt_r == 8'h80)
      else $error("program before full latch");
   chk_verify_hold: assert property (flash_prog |-> ##[130:1000] call_done)
      else $error("no done after verify");
   chk_page_readback: assert property (page_wr_rd |=> reg_rdata == $past(reg_wdata, 2))
      else $error("page select readback wrong");
   chk_boot_pair: assert property (soft_boot |-> internal_reset ##1 !call_busy)
      else $error("boot reset pulses wrong");
   chk_trim_fail: assert property (internal_reset && !soft_boot |-> !trim_sum_ok && !call_done)
      else $error("internal reset without bad trim");
endmodule

// File: fsf_sequencer_test.sv
// Purpose: directed test of the supervisory service sequencer
// Assumes: parameter block preloaded in the ram model by the caller
// Notes: block count and verify wait are shortened for run time
`timescale 1ns/1ps
module fsf_sequencer_test;
   localparam int NB = 4;
   logic clk, arst_n, call_req, call_external, trim_sum_ok, reg_we, reg_re, corrupt, slow;
   logic [7:0] call_func, call_sp, reg_addr, reg_wdata, acc_out, ram_wdata, ram_rdata;
   logic [7:0] flash_rdata, latch_wdata, trim_rdata, trim_wdata, reg_rdata, d, ev, v;
   logic call_busy, call_done, core_halt, ram_we, latch_we, flash_prog, flash_erase_all;
   logic flash_op_done, trim_we, internal_reset, soft_boot;
   logic [10:0] ram_addr;
   logic [13:0] flash_addr;
   logic [6:0] latch_addr;
   logic [2:0] trim_addr;
   logic [1:0] prot_mode;
   logic [15:0] s;
   logic [7:0] cnts [4] = '{8'h01, 8'h00, 8'h04, 8'hc8};
   int fails, cmp_count, pc;
   fsf_sequencer #(.NUM_BLOCKS(NB), .VERIFY_EXTRA_CYC(4)) fsf_sequencer_i (.clk, .arst_n,
      .call_req, .call_func, .call_sp, .call_external, .call_busy, .call_done, .core_halt,
      .acc_out, .ram_we, .ram_addr, .ram_wdata, .ram_rdata, .flash_addr, .flash_rdata,
      .latch_we, .latch_addr, .latch_wdata, .flash_prog, .flash_erase_all, .flash_op_done,
      .prot_mode, .trim_rdata, .trim_addr, .trim_we, .trim_wdata, .trim_sum_ok,
      .internal_reset, .soft_boot, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata);
   fsf_partner fsf_partner_i (.clk, .ram_we, .ram_addr, .ram_wdata, .ram_rdata, .flash_addr,
      .flash_rdata, .latch_we, .latch_addr, .latch_wdata, .flash_prog, .flash_erase_all,
      .flash_op_done, .trim_addr, .trim_rdata, .trim_we, .trim_wdata, .corrupt, .slow);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ****
   // tasks
   // ****
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t sum %h exp %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] wd);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= wd;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] rd);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   task automatic pulse_reset();
      @(posedge clk);
      arst_n <= 1'b0;
      @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
   endtask
   // keys go in first, as the caller must before each call
   task automatic run_call(input logic [7:0] fn, k2, input logic ext, input logic [7:0] blk, ptr);
      fsf_partner_i.ram[11'h0f8] = fsf_pkg::KEY_ONE_VALUE;
      fsf_partner_i.ram[11'h0f9] = k2;
      fsf_partner_i.ram[11'h0fa] = blk;
      fsf_partner_i.ram[11'h0fb] = ptr;
      @(posedge clk);
      call_req <= 1'b1;
      call_func <= fn;
      call_external <= ext;
      @(posedge clk);
      call_req <= 1'b0;
      ev = 8'h00;
      for (int n = 0; n < 20000 && ev == 8'h00; n++) begin
         #1;
         if (call_done === 1'b1) ev = 8'h01;
         else if (core_halt === 1'b1) ev = 8'h02;
         else if (soft_boot === 1'b1) ev = 8'h04;
         else if (internal_reset === 1'b1) ev = 8'h03;
         @(posedge clk);
      end
      // one more edge so the last key write has landed in the ram model
      @(posedge clk);
      if (ev == 8'h00) begin
         fails++;
         $display("CHECK FAILED t=%0t call never ended", $time);
         summarize();
      end
   endtask
   // ****
   // main sequence
   // ****
   initial begin
      fails = 0;
      cmp_count = 0;
      {arst_n, call_req, call_external, reg_we, reg_re, corrupt, slow} = '0;
      {call_func, reg_addr, reg_wdata, prot_mode} = '0;
      call_sp = 8'h20;
      trim_sum_ok = 1'b1;
      for (int i = 0; i < 16384; i++) fsf_partner_i.flash[i] = 8'(i) ^ 8'(i >> 6);
      for (int i = 0; i < 8; i++) fsf_partner_i.trim_src[i] = 8'h50 + 8'(i);
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      reg_rd(8'hd4, d); cmp8(d, fsf_pkg::PAGE_RESET);
      reg_rd(8'h3c, d); cmp8(d, 8'h00);
      reg_wr(8'hd4, 8'h02); reg_rd(8'hd4, d); cmp8(d, 8'h02);
      reg_wr(8'hd5, 8'h02); reg_rd(8'hd5, d); cmp8(d, 8'h02);
      for (int k = 0; k < 4; k++) begin
         run_call(fsf_pkg::FN_CHECKSUM, 8'h23, 1'b0, cnts[k], 8'h00); cmp8(ev, 8'h01);
         s = 16'h0000;
         for (int i = 0; i < ((cnts[k] == 0 || cnts[k] >= NB) ? NB : cnts[k]) * 128; i++)
            s = s + 16'(fsf_partner_i.flash[i]);
         cmp16({fsf_partner_i.ram[11'h0f9], fsf_partner_i.ram[11'h0f8]}, s);
      end
      for (int i = 0; i < 128; i++) fsf_partner_i.ram[{3'd2, 8'h10 + 8'(i)}] = 8'(i * 3 + 1);
      run_call(fsf_pkg::FN_PROG_VERIFY, 8'h23, 1'b0, 8'h01, 8'h10); cmp8(ev, 8'h01);
      cmp8(fsf_partner_i.ram[11'h0f8], fsf_pkg::RES_OK);
      for (int i = 0; i < 128; i++) cmp8(fsf_partner_i.flash[128 + i], 8'(i * 3 + 1));
      corrupt <= 1'b1;
      slow <= 1'b1;
      run_call(fsf_pkg::FN_PROG_VERIFY, 8'h23, 1'b0, 8'h01, 8'h10); cmp8(ev, 8'h01);
      cmp8(fsf_partner_i.ram[11'h0f8], fsf_pkg::RES_VERIFY_FAIL);
      {corrupt, slow} <= 2'b00;
      prot_mode <= 2'b11;
      pc = fsf_partner_i.prog_cnt;
      run_call(fsf_pkg::FN_PROG_VERIFY, 8'h23, 1'b0, 8'h01, 8'h10); cmp8(ev, 8'h01);
      cmp8(fsf_partner_i.ram[11'h0f8], fsf_pkg::RES_PROT_FAIL);
      cmp8(fsf_partner_i.ram[11'h0f9], 8'h00);
      cmp8(acc_out, 8'h00);
      cmp8(8'(fsf_partner_i.prog_cnt - pc), 8'h00);
      prot_mode <= 2'b00;
      run_call(fsf_pkg::FN_PLAIN_TRIM, 8'h23, 1'b0, 8'h00, 8'h00); cmp8(ev, 8'h01);
      for (int i = 0; i < 8; i++) cmp8(fsf_partner_i.trim_reg[i], 8'h50 + 8'(i));
      for (int i = 0; i < 39; i++) fsf_partner_i.ram[{3'd2, 8'h40 + 8'(i)}] = 8'hff;
      run_call(fsf_pkg::FN_CHECKED_TRIM, 8'h23, 1'b0, 8'h00, 8'h40); cmp8(ev, 8'h01);
      for (int i = 0; i < 39; i++)
         cmp8(fsf_partner_i.ram[{3'd2, 8'h40 + 8'(i)}], i < 38 ? 8'h00 : 8'hff);
      trim_sum_ok <= 1'b0;
      run_call(fsf_pkg::FN_CHECKED_TRIM, 8'h23, 1'b0, 8'h00, 8'h40); cmp8(ev, 8'h03);
      reg_rd(fsf_pkg::REG_SYS_STATUS_ONE, d); cmp8({7'h00, d[0]}, 8'h01);
      trim_sum_ok <= 1'b1;
      run_call(fsf_pkg::FN_BOOT_RESET, 8'h23, 1'b0, 8'h00, 8'h00); cmp8(ev, 8'h04);
      run_call(fsf_pkg::FN_CHECKSUM, 8'h24, 1'b0, 8'h01, 8'h00); cmp8(ev, 8'h02);
      repeat (3) @(posedge clk);
      reg_rd(fsf_pkg::REG_SVC_STATUS, d); cmp8({7'h00, d[1]}, 8'h01);
      pulse_reset();
      reg_rd(fsf_pkg::REG_SVC_STATUS, d); cmp8({7'h00, d[1]}, 8'h00);
      v = fsf_partner_i.flash[5];
      run_call(fsf_pkg::FN_BULK_ERASE, 8'h23, 1'b0, 8'h00, 8'h00); cmp8(ev, 8'h02);
      cmp8(fsf_partner_i.flash[5], v);
      pulse_reset();
      slow <= 1'b1;
      run_call(fsf_pkg::FN_BULK_ERASE, 8'h23, 1'b1, 8'h00, 8'h00); cmp8(ev, 8'h01);
      cmp8(fsf_partner_i.flash[5], 8'h00);
      cmp8(fsf_partner_i.flash[NB * 128 - 1], 8'h00);
      cmp8(fsf_partner_i.ram[11'h0f8], fsf_pkg::RES_OK);
      summarize();
   end
endmodule
bind fsf_sequencer fsf_sva fsf_sva_i (.clk, .arst_n, .call_req, .call_external, .call_busy,
   .call_done, .core_halt, .ram_we, .ram_addr, .latch_we, .flash_prog, .flash_erase_all,
   .trim_sum_ok, .internal_reset, .soft_boot, .reg_addr, .reg_wdata, .reg_we, .reg_re,
   .reg_rdata);
